/* hw/nwr_pkg.sv */
// Package for the network word receive controller and its remote node model.
// Assumes a 250 MHz system clock and 16-bit data words.
package nwr_pkg;
  // ------------------------------------------------------------------
  // Register offsets (byte addresses, one 32-bit word each)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFS_COUNT  = 8'h00;
  localparam logic [7:0] OFS_NETCFG = 8'h04;
  localparam logic [7:0] OFS_NODE   = 8'h08;
  localparam logic [7:0] OFS_SRC    = 8'h0C;
  localparam logic [7:0] OFS_DST    = 8'h10;
  localparam logic [7:0] OFS_DSTEND = 8'h14;
  localparam logic [7:0] OFS_EXEC   = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ------------------------------------------------------------------
  // Field positions and limits
  // ------------------------------------------------------------------
  localparam int          NET_SEL_BIT   = 15;
  localparam int          LEVEL_BIT     = 14;
  localparam logic [15:0] NET1_RSV_MASK = 16'h_BF00;
  localparam logic [15:0] NET2_RSV_MASK = 16'h_3000;
  localparam logic [15:0] NET1_MAX_CNT  = 16'h_03E8;
  localparam logic [15:0] NET2_MAX_CNT  = 16'h_0100;
  localparam logic [7:0]  NET1_MAX_NET  = 8'h_7F;
  localparam logic [7:0]  NET1_MAX_NODE = 8'h_7E;
  localparam logic [7:0]  NET1_MIN_NODE = 8'h_01;
  localparam logic [7:0]  NET2_MAX_NODE = 8'h_3E;
  localparam logic [7:0]  NET1_MAX_PORT = 8'h_02;
  localparam logic [7:0]  LIMIT_DEFAULT = 8'h_00;
  localparam logic [7:0]  LIMIT_NONE    = 8'h_FF;
  localparam logic [7:0]  LIMIT_DEF_TNT = 8'h_14;
  localparam logic [7:0]  NET1_TOUT_TNT = 8'h_0A;

  // Status bits
  localparam int ST_ENABLE  = 0;
  localparam int ST_ERROR   = 1;
  localparam int ST_INSTERR = 2;
  localparam int ST_BUSY    = 3;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h_0000;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int TENTH_SEC_NS  = 100000000;
  localparam int TENTH_CYC_DEF = TENTH_SEC_NS / CLK_PERIOD_NS;
  localparam int NODE_LAT_DEF  = 4;

  typedef enum logic {NWR_NET1, NWR_NET2} nwr_net_e;
endpackage

/* hw/nwr_link_if.sv */
// Link between the receive controller and the remote node.
// Command/response exchange; the controller acknowledges every response.
`timescale 1ns/1ps
interface nwr_link_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        cmd_net2;
  logic [7:0]  cmd_network;
  logic [7:0]  cmd_node;
  logic [7:0]  cmd_port;
  logic        cmd_level0;
  logic [15:0] cmd_src;
  logic [15:0] cmd_count;
  logic        rsp_valid;
  logic        rsp_ready;
  logic [15:0] rsp_data;
  logic        rsp_last;
  logic        rsp_err;
  logic        rsp_ack;

  modport dev  (output cmd_valid, cmd_net2, cmd_network, cmd_node, cmd_port, cmd_level0,
                cmd_src, cmd_count, rsp_ready, rsp_ack,
                input cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_err);
  modport node (input cmd_valid, cmd_net2, cmd_network, cmd_node, cmd_port, cmd_level0,
                cmd_src, cmd_count, rsp_ready, rsp_ack,
                output cmd_ready, rsp_valid, rsp_data, rsp_last, rsp_err);
endinterface

/* hw/nwr_node.sv */
// Remote node end: serves a block of words from its own memory.
// Assumes the controller holds a command until cmd_ready and acks each response.
`timescale 1ns/1ps
module nwr_node
  import nwr_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int LAT   = NODE_LAT_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  nwr_link_if.node         link,
  input  wire logic        load_we_i,
  input  wire logic [15:0] load_addr_i,
  input  wire logic [15:0] load_data_i,
  input  wire logic        mute_i,
  input  wire logic        fault_i,
  output logic             busy_o
);
  typedef enum logic [1:0] {ND_IDLE, ND_LAT, ND_SEND, ND_ACK} nwr_nd_e;

  logic [15:0] mem [DEPTH];
  nwr_nd_e     st_q;
  logic [15:0] addr_q;
  logic [15:0] left_q;
  logic [7:0]  lat_q;
  logic        rdy_q;
  logic        vld_q;
  logic [15:0] dat_q;
  logic        last_q;
  logic        err_q;
  logic        mute_q;

  wire logic        take     = link.cmd_valid & rdy_q;
  wire logic        beat     = vld_q & link.rsp_ready;
  wire logic [15:0] beats    = (link.cmd_count == 16'h_0000) ? 16'h_0001 : link.cmd_count;
  wire logic [15:0] rd_addr  = (beat && !last_q) ? addr_q + 16'h_0001 : addr_q;

  assign link.cmd_ready = rdy_q;
  assign link.rsp_valid = vld_q;
  assign link.rsp_data  = dat_q;
  assign link.rsp_last  = last_q;
  assign link.rsp_err   = err_q;

  always_ff @(posedge clk_i) begin
    if (load_we_i) begin
      mem[load_addr_i[$clog2(DEPTH)-1:0]] <= load_data_i;
    end
  end

  // ------------------------------------------------------------------
  // Response sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q   <= ND_IDLE;
      rdy_q  <= 1'b1;
      vld_q  <= 1'b0;
      addr_q <= RST_WORD;
      left_q <= RST_WORD;
      lat_q  <= 8'h_00;
      dat_q  <= RST_WORD;
      last_q <= 1'b0;
      err_q  <= 1'b0;
      busy_o <= 1'b0;
      mute_q <= 1'b0;
    end else begin
      case (st_q)
        ND_IDLE: begin
          if (take) begin
            rdy_q  <= 1'b0;
            busy_o <= 1'b1;
            addr_q <= link.cmd_src;
            left_q <= beats;
            lat_q  <= 8'(LAT);
            mute_q <= mute_i;
            // A muted node swallows the command: the controller must time out
            st_q   <= mute_i ? ND_ACK : ND_LAT;
          end
        end
        ND_LAT: begin
          if (lat_q == 8'h_00) begin
            vld_q  <= 1'b1;
            dat_q  <= mem[addr_q[$clog2(DEPTH)-1:0]];
            last_q <= (left_q == 16'h_0001);
            err_q  <= fault_i && (left_q == 16'h_0001);
            st_q   <= ND_SEND;
          end else begin
            lat_q <= lat_q - 8'h_01;
          end
        end
        ND_SEND: begin
          if (beat) begin
            if (last_q) begin
              vld_q <= 1'b0;
              st_q  <= ND_ACK;
            end else begin
              addr_q <= rd_addr;
              left_q <= left_q - 16'h_0001;
              dat_q  <= mem[rd_addr[$clog2(DEPTH)-1:0]];
              last_q <= (left_q == 16'h_0002);
              err_q  <= fault_i && (left_q == 16'h_0002);
            end
          end
        end
        ND_ACK: begin
          // R17: exchange ends on the requester's acknowledge, or on the next command after a swallowed one
          // Swallowed command is remembered, so unmuting cannot strand the node
          if (link.rsp_ack || (link.cmd_valid && mute_q)) begin
            rdy_q  <= 1'b1;
            mute_q <= 1'b0;
            busy_o <= 1'b0;
            last_q <= 1'b0;
            err_q  <= 1'b0;
            st_q   <= ND_IDLE;
          end
        end
        default: st_q <= ND_IDLE;
      endcase
    end
  end
endmodule

/* hw/nwr_dev.sv */
// Network word receive controller: fetches a block of words from a remote
// node and writes it to local memory. Software drives it over classic
// Wishbone; local memory writes leave on a plain write port.
// Contract
// R01: Execution condition false means no action.
// R02: Copy remote block into local destination words.
// R03: Control word 1 bit 15 selects network.
// R04: Program keeps control words valid, one area.
// R05: First network count is 0 to 1000.
// R06: First network: network number, level, zeros.
// R07: First network: source node and port.
// R08: Network number zero means local subnetwork.
// R09: Second network count is 0 to 256.
// R10: Second network low byte is time limit.
// R11: Second network retries, level, fixed bits.
// R12: Second network source node 0 to 62.
// R13: Node out of range raises instruction error.
// R14: Destination overrun raises instruction error.
// R15: Bad indirect operand raises instruction error.
// R16: Missing link unit raises instruction error.
// R17: Transfer completes after response is acknowledged.
// R18: Enable low while busy, high at end.
// R19: Program starts only while enable high.
// R20: Error flag cleared on success, set on failure.
// R21: Timeout and data errors both report failure.
// R22: Request at execution, finish in service phase.
// R23: Words written in ascending order.
//
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module nwr_dev
  import nwr_pkg::*;
#(
  parameter int TENTH_CYC = TENTH_CYC_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        unit_mounted_i,
  input  wire logic        operand_ok_i,
  input  wire logic        end_of_scan_i,
  input  wire logic        service_phase_i,
  output logic             mem_we_o,
  output logic [15:0]      mem_addr_o,
  output logic [15:0]      mem_data_o,
  output logic             enable_o,
  output logic             error_o,
  output logic             instr_err_o,
  nwr_link_if.dev          link
);
  typedef enum logic [2:0] {DV_IDLE, DV_SEND, DV_WAIT, DV_FINAL, DV_END} nwr_dv_e;

  nwr_dv_e     st_q;
  logic [15:0] cnt_q, net_q, node_q, src_q, dst_q, dend_q;
  logic        exec_q;
  logic [15:0] idx_q;
  logic [3:0]  retry_q;
  logic [24:0] tick_q;
  logic [7:0]  tenth_q;
  logic        ok_q;
  logic        cmd_q;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire logic        wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic        wb_wr   = wb_req & wb_we_i & (&wb_sel_i[1:0]);
  // R03: network select from bit 15
  wire logic        net2    = net_q[NET_SEL_BIT];
  wire logic [7:0]  node    = node_q[7:0];
  wire logic [16:0] last_a  = {1'b0, dst_q} + {1'b0, cnt_q} - 17'h_0_0001;
  // R05 R09: count limits per network
  wire logic        cnt_bad = net2 ? (cnt_q > NET2_MAX_CNT) : (cnt_q > NET1_MAX_CNT);
  // R06 R11: reserved bits and field ranges
  wire logic        cfg_bad = net2 ? ((net_q & NET2_RSV_MASK) != 16'h_0000)
                                   : (((net_q & NET1_RSV_MASK) != 16'h_0000)
                                      || (net_q[7:0] > NET1_MAX_NET));
  // R07 R12 R13: node and port ranges
  wire logic        node_bad = net2 ? ((node > NET2_MAX_NODE) || (node_q[15:8] != 8'h_00))
                                    : ((node > NET1_MAX_NODE) || (node < NET1_MIN_NODE)
                                       || (node_q[15:8] > NET1_MAX_PORT));
  // R14: block must end inside the destination area
  wire logic        ovr_bad = (cnt_q != 16'h_0000) && (last_a > {1'b0, dend_q});
  // R15 R16: operand and link unit checks
  wire logic        chk_bad = cnt_bad | cfg_bad | node_bad | ovr_bad
                              | ~operand_ok_i | ~unit_mounted_i;
  // R10: time limit in tenths, zero means default, all ones means none
  wire logic [7:0]  limit   = !net2 ? NET1_TOUT_TNT
                              : (net_q[7:0] == LIMIT_DEFAULT) ? LIMIT_DEF_TNT : net_q[7:0];
  wire logic        no_lim  = net2 && (net_q[7:0] == LIMIT_NONE);
  wire logic        tick    = (tick_q == 25'(TENTH_CYC - 1));
  wire logic        tout    = !no_lim && tick && (tenth_q == 8'h_01);
  wire logic        beat    = link.rsp_valid & link.rsp_ready;
  wire logic        fail    = tout || (beat && link.rsp_last && link.rsp_err);
  // R01 R19: start only on execution with flag high and idle
  wire logic        start   = exec_q && enable_o && (st_q == DV_IDLE);

  assign link.cmd_valid   = cmd_q;
  assign link.cmd_net2    = net2;
  // R08: zero network number passes through as local subnetwork
  assign link.cmd_network = net2 ? 8'h_00 : net_q[7:0];
  assign link.cmd_node    = node;
  assign link.cmd_port    = net2 ? 8'h_00 : node_q[15:8];
  assign link.cmd_level0  = net_q[LEVEL_BIT];
  assign link.cmd_src     = src_q;
  assign link.cmd_count   = cnt_q;
  assign link.rsp_ready   = (st_q == DV_WAIT) && !(link.rsp_last && !service_phase_i);
  assign link.rsp_ack     = (st_q == DV_FINAL) && service_phase_i;

  // ------------------------------------------------------------------
  // Wishbone slave, answers one cycle after the request
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h_0000_0000;
      cnt_q    <= RST_WORD;
      net_q    <= RST_WORD;
      node_q   <= RST_WORD;
      src_q    <= RST_WORD;
      dst_q    <= RST_WORD;
      dend_q   <= RST_WORD;
      exec_q   <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_wr) begin
        case (wb_adr_i)
          OFS_COUNT:  cnt_q  <= wb_dat_i[15:0];
          OFS_NETCFG: net_q  <= wb_dat_i[15:0];
          OFS_NODE:   node_q <= wb_dat_i[15:0];
          OFS_SRC:    src_q  <= wb_dat_i[15:0];
          OFS_DST:    dst_q  <= wb_dat_i[15:0];
          OFS_DSTEND: dend_q <= wb_dat_i[15:0];
          OFS_EXEC:   exec_q <= wb_dat_i[0];
          default:    ;
        endcase
      end
      case (wb_adr_i)
        OFS_COUNT:  wb_dat_o <= {16'h_0000, cnt_q};
        OFS_NETCFG: wb_dat_o <= {16'h_0000, net_q};
        OFS_NODE:   wb_dat_o <= {16'h_0000, node_q};
        OFS_SRC:    wb_dat_o <= {16'h_0000, src_q};
        OFS_DST:    wb_dat_o <= {16'h_0000, dst_q};
        OFS_DSTEND: wb_dat_o <= {16'h_0000, dend_q};
        OFS_EXEC:   wb_dat_o <= {31'h_0000_0000, exec_q};
        OFS_STATUS: wb_dat_o <= {28'h_000_0000, (st_q != DV_IDLE), instr_err_o,
                                 error_o, enable_o};
        default:    wb_dat_o <= 32'h_0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q        <= DV_IDLE;
      enable_o    <= 1'b1;
      error_o     <= 1'b0;
      instr_err_o <= 1'b0;
      cmd_q       <= 1'b0;
      idx_q       <= RST_WORD;
      retry_q     <= 4'h_0;
      tick_q      <= 25'h_000_0000;
      tenth_q     <= 8'h_00;
      ok_q        <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= RST_WORD;
      mem_data_o  <= RST_WORD;
    end else begin
      mem_we_o <= 1'b0;
      tick_q   <= (st_q == DV_WAIT && !tick) ? tick_q + 25'h_000_0001 : 25'h_000_0000;
      if (st_q == DV_WAIT && tick && !no_lim) begin
        tenth_q <= tenth_q - 8'h_01;
      end
      case (st_q)
        DV_IDLE: begin
          if (start) begin
            // R13 R14 R15 R16: bad operands stop before any transfer
            instr_err_o <= chk_bad;
            if (!chk_bad) begin
              // R18: enable falls for the whole exchange
              enable_o <= 1'b0;
              // R22: request goes out at execution
              cmd_q    <= 1'b1;
              retry_q  <= net2 ? net_q[11:8] : 4'h_0;
              st_q     <= DV_SEND;
            end
          end
        end
        DV_SEND: begin
          idx_q   <= RST_WORD;
          tenth_q <= limit;
          if (link.cmd_ready) begin
            cmd_q <= 1'b0;
            st_q  <= DV_WAIT;
          end
        end
        DV_WAIT: begin
          if (beat && idx_q < cnt_q) begin
            // R02 R23: ascending local addresses, source order kept
            mem_we_o   <= !(link.rsp_last && link.rsp_err);
            mem_addr_o <= dst_q + idx_q;
            mem_data_o <= link.rsp_data;
            idx_q      <= idx_q + 16'h_0001;
          end
          // R21: timeout or data error is a failed attempt
          if (fail) begin
            if (retry_q != 4'h_0) begin
              retry_q <= retry_q - 4'h_1;
              cmd_q   <= 1'b1;
              st_q    <= tout ? DV_SEND : DV_FINAL;
              ok_q    <= 1'b0;
            end else begin
              ok_q <= 1'b0;
              st_q <= tout ? DV_END : DV_FINAL;
            end
          end else if (beat && link.rsp_last) begin
            ok_q <= 1'b1;
            st_q <= DV_FINAL;
          end
        end
        DV_FINAL: begin
          // R17 R22: acknowledge the response in the service phase
          if (service_phase_i) begin
            st_q <= (cmd_q && !ok_q) ? DV_SEND : DV_END;
          end
        end
        DV_END: begin
          cmd_q <= 1'b0;
          // R18 R20: flags settle at the next end of program
          if (end_of_scan_i) begin
            enable_o <= 1'b1;
            error_o  <= !ok_q;
            st_q     <= DV_IDLE;
          end
        end
        default: st_q <= DV_IDLE;
      endcase
    end
  end
endmodule

/* sim/nwr_properties.sv */
// Link assertions for the receive controller facing the remote node.
// Takes the link signals as plain inputs; instantiated beside the link.
`timescale 1ns/1ps
module nwr_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic        cmd_net2,
  input wire logic [7:0]  cmd_network,
  input wire logic [7:0]  cmd_node,
  input wire logic [7:0]  cmd_port,
  input wire logic [15:0] cmd_src,
  input wire logic [15:0] cmd_count,
  input wire logic        rsp_valid,
  input wire logic        rsp_ready,
  input wire logic        rsp_last,
  input wire logic        rsp_ack
);
  // ----------------------------------------
  // Helper: last beat taken, ack not yet given
  // ----------------------------------------
  logic last_q;
  logic last_d;
  assign last_d = rsp_ack ? 1'b0 : (last_q | (rsp_valid & rsp_ready & rsp_last));
  always_ff @(posedge clk_i) begin
    last_q <= rst_i ? 1'b0 : last_d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_cmd_held_ready: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_src) && $stable(cmd_count)) else $error("command dropped early");
  a_cmd_drop_taken: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
    else $error("command stays after take");
  a_net1_node_rng: assert property (cmd_valid && !cmd_net2 |->
    cmd_node >= 8'h01 && cmd_node <= 8'h7E) else $error("first network node out of range");
  a_net2_node_rng: assert property (cmd_valid && cmd_net2 |-> cmd_node <= 8'h3E)
    else $error("second network node out of range");
  a_net1_port_net: assert property (cmd_valid && !cmd_net2 |->
    cmd_port <= 8'h02 && cmd_network <= 8'h7F) else $error("first network port or net bad");
  a_count_limit: assert property (cmd_valid |->
    cmd_count <= (cmd_net2 ? 16'h0100 : 16'h03E8)) else $error("word count out of range");
  a_ack_one_pulse: assert property ($rose(rsp_ack) |=> !rsp_ack)
    else $error("ack longer than one cycle");
  a_ack_after_last: assert property (rsp_ack |-> last_q && !rsp_valid)
    else $error("ack without a taken last beat");
endmodule

/* sim/network_word_receive_tb.sv */
// Self-checking bench: controller and node joined by the link interface.
// Assumes Wishbone answers within 50 cycles and the node serves 16 preset words.
`timescale 1ns/1ps
module network_word_receive_tb import nwr_pkg::*;;
  typedef struct {
    logic [15:0] cnt;
    logic [15:0] cfg;
    logic [15:0] nd;
    logic        ie;
    logic [15:0] words;
  } nwr_row_s;

  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h_0000_0000, wb_dat_o;
  logic        wb_ack_o, mem_we_o, enable_o, error_o, instr_err_o, busy_o;
  logic [15:0] mem_addr_o, mem_data_o, wr_cnt = 16'h0000;
  logic        unit_mounted_i = 1'b1, operand_ok_i = 1'b1, mute_i = 1'b0, fault_i = 1'b0;
  logic        end_of_scan_i = 1'b0, service_phase_i = 1'b0, load_we_i = 1'b0;
  logic [15:0] load_addr_i = 16'h0000, load_data_i = 16'h0000;
  logic [2:0]  scan_q = 3'h0;
  logic [31:0] q;
  int          fails = 0, checks = 0;

  nwr_link_if link_i ();
  nwr_dev #(.TENTH_CYC(20)) u_nwr_dev (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .unit_mounted_i(unit_mounted_i), .operand_ok_i(operand_ok_i), .end_of_scan_i(end_of_scan_i),
    .service_phase_i(service_phase_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o), .enable_o(enable_o), .error_o(error_o),
    .instr_err_o(instr_err_o), .link(link_i));
  nwr_node u_nwr_node (.clk_i(clk_i), .rst_i(rst_i), .link(link_i), .load_we_i(load_we_i),
    .load_addr_i(load_addr_i), .load_data_i(load_data_i), .mute_i(mute_i), .fault_i(fault_i),
    .busy_o(busy_o));
  nwr_properties u_nwr_properties (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid(link_i.cmd_valid), .cmd_ready(link_i.cmd_ready), .cmd_net2(link_i.cmd_net2),
    .cmd_network(link_i.cmd_network), .cmd_node(link_i.cmd_node), .cmd_port(link_i.cmd_port),
    .cmd_src(link_i.cmd_src), .cmd_count(link_i.cmd_count), .rsp_valid(link_i.rsp_valid),
    .rsp_ready(link_i.rsp_ready), .rsp_last(link_i.rsp_last), .rsp_ack(link_i.rsp_ack));

  initial forever #2 clk_i = ~clk_i;

  // ----------------------------------------
  // Scan: service phase in the second half, end point at its close
  // ----------------------------------------
  always @(posedge clk_i) begin
    scan_q <= scan_q + 3'h1;
    service_phase_i <= scan_q[2];
    end_of_scan_i <= (scan_q == 3'h7);
  end

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // Local writes land from 0x0100 up; node word i holds 0x5A00 + i, source at 4
  always @(posedge clk_i) begin
    if (mem_we_o === 1'b1) begin
      check("mem_addr", {16'h0000, 16'h0100 + wr_cnt}, {16'h0000, mem_addr_o});
      check("mem_data", {16'h0000, 16'h5A04 + wr_cnt}, {16'h0000, mem_data_o});
      wr_cnt = wr_cnt + 16'h0001;
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 50) fails++;
  endtask

  // Exec is pulsed so a held condition cannot re-trigger after completion
  task automatic run_op(input logic [15:0] cnt, cfg, nd, input logic ie, er,
                        input logic [15:0] words);
    int n = 0;
    wr_cnt = 16'h0000;
    wb(1'b1, OFS_COUNT, {16'h0000, cnt});
    wb(1'b1, OFS_NETCFG, {16'h0000, cfg});
    wb(1'b1, OFS_NODE, {16'h0000, nd});
    wb(1'b1, OFS_EXEC, 32'h_0000_0001);
    wb(1'b1, OFS_EXEC, 32'h_0000_0000);
    check("enable_busy", {31'h0, ie}, {31'h0, enable_o});
    while (enable_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    check("enable_done", 32'h_0000_0001, {31'h0, enable_o});
    check("instr_err", {31'h0, ie}, {31'h0, instr_err_o});
    check("error", {31'h0, er}, {31'h0, error_o});
    if (words !== 16'hFFFF) check("words", {16'h0000, words}, {16'h0000, wr_cnt});
  endtask

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    complete_run;
  end

  nwr_row_s rows [14] = '{
    '{16'h0002, 16'h0000, 16'h0005, 1'b0, 16'h0002}, '{16'h0000, 16'h4003, 16'h0101, 1'b0, 16'h0000},
    '{16'h0003, 16'h8005, 16'h003E, 1'b0, 16'h0003}, '{16'h0001, 16'h0000, 16'h027E, 1'b0, 16'h0001},
    '{16'h0001, 16'h8F00, 16'h0000, 1'b0, 16'h0001}, '{16'h0001, 16'h0000, 16'h007F, 1'b1, 16'h0000},
    '{16'h0001, 16'h8000, 16'h003F, 1'b1, 16'h0000}, '{16'h03E9, 16'h0000, 16'h0005, 1'b1, 16'h0000},
    '{16'h0101, 16'h8000, 16'h0005, 1'b1, 16'h0000}, '{16'h0001, 16'h0100, 16'h0005, 1'b1, 16'h0000},
    '{16'h0001, 16'h9000, 16'h0005, 1'b1, 16'h0000}, '{16'h0001, 16'h0000, 16'h0305, 1'b1, 16'h0000},
    '{16'h0001, 16'h0080, 16'h0005, 1'b1, 16'h0000}, '{16'h0001, 16'h0000, 16'h0000, 1'b1, 16'h0000}};

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h_0000_0000);
    check("status_reset", 32'h_0000_0001, q);
    wb(1'b0, 8'h40, 32'h_0000_0000);
    check("unmapped", 32'h_0000_0000, q);
    for (int i = 0; i < 16; i++) begin
      load_we_i <= 1'b1;
      load_addr_i <= i[15:0];
      load_data_i <= 16'h5A00 + i[15:0];
      @(posedge clk_i);
    end
    load_we_i <= 1'b0;
    wb(1'b1, OFS_SRC, 32'h_0000_0004);
    wb(1'b1, OFS_DST, 32'h_0000_0100);
    wb(1'b1, OFS_DSTEND, 32'h_0000_FFFF);
    wb(1'b1, OFS_COUNT, 32'h_0000_0002);
    repeat (20) @(posedge clk_i);
    check("idle_writes", 32'h_0000_0000, {16'h0000, wr_cnt});
    foreach (rows[i]) begin
      run_op(rows[i].cnt, rows[i].cfg, rows[i].nd, rows[i].ie, 1'b0, rows[i].words);
    end
    wb(1'b1, OFS_DSTEND, 32'h_0000_0101);
    run_op(16'h0003, 16'h0000, 16'h0005, 1'b1, 1'b0, 16'h0000);
    wb(1'b1, OFS_DSTEND, 32'h_0000_01FF);
    unit_mounted_i <= 1'b0;
    run_op(16'h0001, 16'h0000, 16'h0005, 1'b1, 1'b0, 16'h0000);
    unit_mounted_i <= 1'b1;
    operand_ok_i <= 1'b0;
    run_op(16'h0001, 16'h0000, 16'h0005, 1'b1, 1'b0, 16'h0000);
    operand_ok_i <= 1'b1;
    mute_i <= 1'b1;
    run_op(16'h0002, 16'h0000, 16'h0005, 1'b0, 1'b1, 16'h0000);
    mute_i <= 1'b0;
    run_op(16'h0002, 16'h0000, 16'h0005, 1'b0, 1'b0, 16'h0002);
    fault_i <= 1'b1;
    run_op(16'h0002, 16'h0000, 16'h0005, 1'b0, 1'b1, 16'hFFFF);
    fault_i <= 1'b0;
    run_op(16'h0001, 16'h0000, 16'h007F, 1'b1, 1'b1, 16'h0000);
    wb(1'b0, OFS_STATUS, 32'h_0000_0000);
    check("status_err", 32'h_0000_0007, q);
    complete_run;
  end
endmodule
